/* File: design/power_wake_defs.vh */
// Purpose: Shared constants of the power, wake-up and host interrupt logic.
// Assumes: 50 MHz device clock, 8-bit register port.
// Notes: Offsets are register addresses on the internal register port.
//
// Notes on behaviour
// - Setting the zero-power request enters low-power mode at once.
// - With network still active, stay in low-power until activity stops.
// - A network wake-up signal wakes the chip from that low-power wait.
// - In zero-power only wake-up logic runs, watching receive input.
// - Every 50 ms scan the input, receiver power low for 150 us.
// - A scan with no activity returns to zero-power for the next one.
// - Wake on receive activity or two SDA, CS or write-strobe falls.
// - Wake-up end sets the error flag and drives the interrupt low.
// - Wake keeps address, retry and alternate packet registers, other registers reset.
// - Interrupt asserts for events whose enable bit is set, and for wake-up end regardless.
// - Enables: bit3 config, bit2 error, bit1 sent, bit0 received.
// - Node count or node delay change sets the config-change flag.
// - Sent message sets sent flag, then result flag on success or error code on failure.
// - Received message sets received flag and records message type.
// - After reset the interrupt goes low regardless of error enable.
// - Host clears an event via message control; line then releases.
// - Clearing one of several events releases the line briefly.
// - Power status output is high during zero-power mode.
`ifndef POWER_WAKE_DEFS_VH
`define POWER_WAKE_DEFS_VH

// Register offsets
`define OFS_MSG_STATUS 8'h85
`define OFS_MSG_CONTROL 8'h86
`define OFS_TX_STATUS 8'h87
`define OFS_INT_MASK 8'h88
`define OFS_RX_TYPE 8'h89
`define OFS_NODE_COUNT 8'h8a
`define OFS_NODE_DELAY 8'h8b
`define OFS_CLK_PWR_CTRL 8'h8c
`define OFS_NODE_ADDR_HI 8'h8d
`define OFS_NODE_ADDR_LO 8'h8e
`define OFS_GROUP_ADDR 8'h8f
`define OFS_RETRY_TIME 8'h90
`define OFS_RETRY_COUNT 8'h91
`define OFS_ALT_PKT_HI 8'h92
`define OFS_ALT_PKT_LO 8'h94

// Event bit positions, shared by status, mask and control registers
`define BIT_RECEIVED 0
`define BIT_SENT 1
`define BIT_ERROR 2
`define BIT_CONFIG 3
`define BIT_TX_RESULT 4
`define INT_MASK_BITS 4'hf
`define INT_MASK_RESET 8'h00

// Clock and power control fields
`define BIT_ZERO_POWER_REQ 0
`define BIT_PWR_STATE_LO 4

// Timing
`define CLK_HZ 50000000
`define SCAN_PERIOD_MS 50
`define SCAN_PULSE_US 150
`define SCAN_CYCLES ((`CLK_HZ / 1000) * `SCAN_PERIOD_MS)
`define PULSE_CYCLES ((`CLK_HZ / 1000000) * `SCAN_PULSE_US)
`define IDLE_CYCLES 256
`define INIT_CYCLES 16

`endif

/* File: design/scan_interval_timer.v */
// Purpose: Free-running scan interval timer of the wake-up logic.
// Assumes: Kept clocked in every power state.
// Notes: Emits a one-cycle tick each period.
`timescale 1ns/1ns
module scan_interval_timer #(
   parameter PERIOD = 2500000
) (
   // Clock and reset
   input wire clk,
   input wire arst_n,
   // Tick out
   output reg tick_q
);
   reg [21:0] cnt_q;

   // Never gated, so the interval holds through zero-power
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 22'h000000;
         tick_q <= 1'b0;
      end else if (cnt_q == PERIOD[21:0] - 22'h000001) begin
         cnt_q <= 22'h000000;
         tick_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 22'h000001;
         tick_q <= 1'b0;
      end
   end
endmodule // scan_interval_timer

/* File: design/port_wake_detect.v */
// Purpose: Detects two falling edges on the active host port line.
// Assumes: Pins are asynchronous; mode comes from same-clock logic.
// Notes: Mode 0 watches SDA, 1 the SPI select, 2 the write strobe.
`timescale 1ns/1ns
module port_wake_detect (
   // Clock and reset
   input wire clk,
   input wire arst_n,
   // Pins
   input wire sda_in,
   input wire cs_n_in,
   input wire wr_n_in,
   // Control
   input wire [1:0] port_mode,
   input wire arm,
   // Result
   output reg wake_q
);
   reg [2:0] meta_q;
   reg [2:0] sync_q;
   reg [2:0] last_q;
   reg [1:0] falls_q;
   reg sel;
   reg sel_last;

   // Two-stage synchroniser, first stage read only by the second
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= 3'h7;
         sync_q <= 3'h7;
         last_q <= 3'h7;
      end else begin
         meta_q <= {wr_n_in, cs_n_in, sda_in};
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // Pick the line of the configured port
   always @* begin
      sel = sync_q[0];
      sel_last = last_q[0];
      case (port_mode)
         2'h1: begin
            sel = sync_q[1];
            sel_last = last_q[1];
         end
         2'h2: begin
            sel = sync_q[2];
            sel_last = last_q[2];
         end
         default: begin
            sel = sync_q[0];
            sel_last = last_q[0];
         end
      endcase
   end

   // One glitch must not wake the chip, so two falls are needed
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         falls_q <= 2'h0;
         wake_q <= 1'b0;
      end else if (!arm) begin
         falls_q <= 2'h0;
         wake_q <= 1'b0;
      end else if (sel_last && !sel) begin
         if (falls_q == 2'h1) begin
            wake_q <= 1'b1;
         end
         falls_q <= 2'h2;
         if (falls_q == 2'h0) begin
            falls_q <= 2'h1;
         end
      end
   end
endmodule // port_wake_detect

/* File: design/power_wake_interrupt_logic.v */
// Purpose: Power states, wake-up scanning and host interrupt.
// Assumes: Register port is the internal side of the host control port.
// Notes: Message events arrive as one-cycle pulses from the core.
`timescale 1ns/1ns
`include "power_wake_defs.vh"
module power_wake_interrupt_logic #(
   parameter SCAN_PERIOD = `SCAN_CYCLES,
   parameter PULSE_LEN = `PULSE_CYCLES,
   parameter IDLE_LEN = `IDLE_CYCLES,
   parameter INIT_LEN = `INIT_CYCLES
) (
   // Clock and reset
   input wire clk,
   input wire arst_n,
   // Register port
   input wire reg_wr,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata_q,
   // Host port pins for wake detection
   input wire [1:0] port_mode,
   input wire sda_in,
   input wire cs_n_in,
   input wire wr_n_in,
   // Network receive pin
   input wire rx_in,
   // Core events
   input wire wake_frame,
   input wire msg_sent,
   input wire tx_ok,
   input wire [7:0] tx_err_code,
   input wire msg_received,
   input wire [7:0] rx_type_in,
   input wire err_event,
   input wire [7:0] node_count_in,
   input wire [7:0] node_delay_in,
   // Pins out
   output reg int_n_q,
   output reg power_status_q,
   output reg rx_power_n_q,
   output reg core_reset_q
);
   localparam ST_INIT = 3'h0;
   localparam ST_ACTIVE = 3'h1;
   localparam ST_LOW = 3'h2;
   localparam ST_ZERO = 3'h3;
   localparam ST_SCAN = 3'h4;

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [12:0] cnt_q;
   reg [12:0] cnt_d;
   reg rx_meta_q;
   reg rx_sync_q;
   reg rx_last_q;
   reg [7:0] idle_q;
   reg zp_req_q;
   reg [4:0] status_q;
   reg [3:0] mask_q;
   reg por_q;
   reg gap_q;
   reg [7:0] tx_status_q;
   reg [7:0] rx_type_q;
   reg [7:0] node_count_q;
   reg [7:0] node_delay_q;
   reg [7:0] node_addr_hi_q;
   reg [7:0] node_addr_lo_q;
   reg [7:0] group_addr_q;
   reg [7:0] retry_time_q;
   reg [7:0] retry_count_q;
   reg [7:0] alt_pkt_hi_q;
   reg [7:0] alt_pkt_lo_q;
   reg [7:0] rdata_d;
   wire scan_tick;
   wire port_wake;
   wire rx_active;
   wire net_idle;
   wire init_done;
   wire wr_ctrl;
   wire wr_msgc;
   wire [4:0] clr;
   wire [4:0] set;
   wire cfg_change;
   wire irq_any;

   scan_interval_timer #(
      .PERIOD(SCAN_PERIOD)
   ) u_timer (
      .clk(clk),
      .arst_n(arst_n),
      .tick_q(scan_tick)
   );

   port_wake_detect u_port (
      .clk(clk),
      .arst_n(arst_n),
      .sda_in(sda_in),
      .cs_n_in(cs_n_in),
      .wr_n_in(wr_n_in),
      .port_mode(port_mode),
      .arm(state_q != ST_ACTIVE && state_q != ST_INIT),
      .wake_q(port_wake)
   );

   // Receive pin synchroniser, third stage for transitions
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_meta_q <= 1'b0;
         rx_sync_q <= 1'b0;
         rx_last_q <= 1'b0;
      end else begin
         rx_meta_q <= rx_in;
         rx_sync_q <= rx_meta_q;
         rx_last_q <= rx_sync_q;
      end
   end

   // A transition is activity; a quiet stretch means the network is idle
   assign rx_active = rx_sync_q != rx_last_q;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         idle_q <= 8'h00;
      end else if (rx_active) begin
         idle_q <= 8'h00;
      end else if (!net_idle) begin
         idle_q <= idle_q + 8'h01;
      end
   end
   assign net_idle = idle_q == IDLE_LEN[7:0] - 8'h01;

   assign wr_ctrl = reg_wr && (reg_addr == `OFS_CLK_PWR_CTRL);
   assign wr_msgc = reg_wr && (reg_addr == `OFS_MSG_CONTROL);
   assign init_done = (state_q == ST_INIT) && (cnt_q == INIT_LEN[12:0]);

   // Power state machine
   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         ST_INIT: begin
            cnt_d = cnt_q + 13'h0001;
            if (init_done) begin
               state_d = ST_ACTIVE;
               cnt_d = 13'h0000;
            end
         end
         ST_ACTIVE: begin
            if (wr_ctrl && reg_wdata[`BIT_ZERO_POWER_REQ]) begin
               state_d = ST_LOW;
            end
         end
         ST_LOW: begin
            if (wake_frame || port_wake) begin
               state_d = ST_INIT;
            end else if (net_idle) begin
               state_d = ST_ZERO;
            end
         end
         ST_ZERO: begin
            if (port_wake) begin
               state_d = ST_INIT;
            end else if (scan_tick) begin
               state_d = ST_SCAN;
               cnt_d = 13'h0000;
            end
         end
         ST_SCAN: begin
            cnt_d = cnt_q + 13'h0001;
            if (rx_active || port_wake) begin
               state_d = ST_INIT;
               cnt_d = 13'h0000;
            end else if (cnt_q == PULSE_LEN[12:0] - 13'h0001) begin
               state_d = ST_ZERO;
               cnt_d = 13'h0000;
            end
         end
         default: begin
            state_d = ST_INIT;
            cnt_d = 13'h0000;
         end
      endcase
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_INIT;
         cnt_q <= 13'h0000;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Pins: in zero-power only the wake-up logic runs
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         power_status_q <= 1'b0;
         rx_power_n_q <= 1'b0;
         core_reset_q <= 1'b1;
      end else begin
         power_status_q <= state_d == ST_ZERO || state_d == ST_SCAN;
         rx_power_n_q <= state_d == ST_ZERO;
         core_reset_q <= state_d != ST_ACTIVE;
      end
   end

   // Event sources; config change is any step of node count or delay
   assign cfg_change = (node_count_in != node_count_q) ||
                       (node_delay_in != node_delay_q);
   assign set[`BIT_RECEIVED] = msg_received;
   assign set[`BIT_SENT] = msg_sent;
   assign set[`BIT_ERROR] = err_event || init_done;
   assign set[`BIT_CONFIG] = cfg_change;
   assign set[`BIT_TX_RESULT] = msg_sent && tx_ok;
   assign clr = wr_msgc ? reg_wdata[4:0] : 5'h00;

   // Sticky flags; a set in the clearing cycle wins
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         status_q <= 5'h00;
         por_q <= 1'b0;
         tx_status_q <= 8'h00;
         rx_type_q <= 8'h00;
         node_count_q <= 8'h00;
         node_delay_q <= 8'h00;
      end else if (state_q == ST_INIT && !init_done) begin
         status_q <= 5'h00;
         por_q <= 1'b0;
         tx_status_q <= 8'h00;
         rx_type_q <= 8'h00;
         node_count_q <= node_count_in;
         node_delay_q <= node_delay_in;
      end else begin
         status_q[3:0] <= (status_q[3:0] & ~clr[3:0]) | set[3:0];
         if (msg_sent) begin
            status_q[`BIT_TX_RESULT] <= tx_ok;
         end else if (clr[`BIT_TX_RESULT]) begin
            status_q[`BIT_TX_RESULT] <= 1'b0;
         end
         if (init_done) begin
            por_q <= 1'b1;
         end else if (clr[`BIT_ERROR]) begin
            por_q <= 1'b0;
         end
         if (msg_sent && !tx_ok) begin
            tx_status_q <= tx_err_code;
         end
         if (msg_received) begin
            rx_type_q <= rx_type_in;
         end
         node_count_q <= node_count_in;
         node_delay_q <= node_delay_in;
      end
   end

   // Host-written registers; mask and request reset on wake
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mask_q <= 4'h0;
         zp_req_q <= 1'b0;
      end else if (state_q == ST_INIT) begin
         mask_q <= 4'h0;
         zp_req_q <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == `OFS_INT_MASK) begin
            mask_q <= reg_wdata[3:0] & `INT_MASK_BITS;
         end
         if (wr_ctrl) begin
            zp_req_q <= reg_wdata[`BIT_ZERO_POWER_REQ];
         end
      end
   end

   // Addresses and retry settings survive wake-up, reset only on arst_n
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         node_addr_hi_q <= 8'h00;
         node_addr_lo_q <= 8'h00;
         group_addr_q <= 8'h00;
         retry_time_q <= 8'h00;
         retry_count_q <= 8'h00;
         alt_pkt_hi_q <= 8'h00;
         alt_pkt_lo_q <= 8'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            `OFS_NODE_ADDR_HI: node_addr_hi_q <= reg_wdata;
            `OFS_NODE_ADDR_LO: node_addr_lo_q <= reg_wdata;
            `OFS_GROUP_ADDR: group_addr_q <= reg_wdata;
            `OFS_RETRY_TIME: retry_time_q <= reg_wdata;
            `OFS_RETRY_COUNT: retry_count_q <= reg_wdata;
            `OFS_ALT_PKT_HI: alt_pkt_hi_q <= reg_wdata;
            `OFS_ALT_PKT_LO: alt_pkt_lo_q <= reg_wdata;
            default: node_addr_hi_q <= node_addr_hi_q;
         endcase
      end
   end

   // Interrupt: enabled flags, or the power-on event regardless of mask.
   // A clear with any of bits 3:0 set forces one high cycle so a second pending event gives a
   // fresh falling edge.
   assign irq_any = (|(status_q[3:0] & mask_q)) || por_q;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gap_q <= 1'b0;
         int_n_q <= 1'b1;
      end else begin
         gap_q <= wr_msgc && (|reg_wdata[3:0]);
         int_n_q <= !irq_any || gap_q;
      end
   end

   // Read data, one cycle after the address; unmapped reads give zero
   always @* begin
      case (reg_addr)
         `OFS_MSG_STATUS: rdata_d = {3'h0, status_q};
         `OFS_TX_STATUS: rdata_d = tx_status_q;
         `OFS_INT_MASK: rdata_d = {4'h0, mask_q};
         `OFS_RX_TYPE: rdata_d = rx_type_q;
         `OFS_NODE_COUNT: rdata_d = node_count_q;
         `OFS_NODE_DELAY: rdata_d = node_delay_q;
         `OFS_CLK_PWR_CTRL: rdata_d = {1'b0, state_q, 3'h0, zp_req_q};
         `OFS_NODE_ADDR_HI: rdata_d = node_addr_hi_q;
         `OFS_NODE_ADDR_LO: rdata_d = node_addr_lo_q;
         `OFS_GROUP_ADDR: rdata_d = group_addr_q;
         `OFS_RETRY_TIME: rdata_d = retry_time_q;
         `OFS_RETRY_COUNT: rdata_d = retry_count_q;
         `OFS_ALT_PKT_HI: rdata_d = alt_pkt_hi_q;
         `OFS_ALT_PKT_LO: rdata_d = alt_pkt_lo_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata_q <= 8'h00;
      end else begin
         reg_rdata_q <= rdata_d;
      end
   end
endmodule // power_wake_interrupt_logic

/* File: sim/power_wake_properties.sv */
// Purpose: Port-level checks of power states and host interrupt.
// Assumes: Sees only ports of the power and interrupt block.
// Notes: Scan figures follow the bound parameters.
`timescale 1ns/1ns
module power_wake_properties #(
   parameter int SCAN_PERIOD = 200,
   parameter int PULSE_LEN = 20,
   parameter int IDLE_LEN = 16
) (
   // Clock and reset
   input wire clk,
   input wire arst_n,
   // Register port
   input wire reg_wr,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata_q,
   // Pins
   input wire rx_in,
   input wire int_n_q,
   input wire power_status_q,
   input wire rx_power_n_q,
   input wire core_reset_q
);
   localparam int GAP_MAX = SCAN_PERIOD + 2;
   localparam int LEN_MAX = PULSE_LEN + 2;
   int low_cnt;
   int quiet_cnt;
   reg rx_last_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Receiver-on run length and quiet time of the raw receive pin
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         low_cnt <= 0;
         quiet_cnt <= 0;
         rx_last_q <= 1'b0;
      end else begin
         low_cnt <= rx_power_n_q ? 0 : low_cnt + 1;
         quiet_cnt <= (rx_in != rx_last_q) ? 0 : quiet_cnt + 1;
         rx_last_q <= rx_in;
      end
   end
   sequence clear_wr;
      reg_wr && reg_addr == 8'h86 && reg_wdata[3:0] != 4'h0;
   endsequence
   sequence zp_wr;
      reg_wr && reg_addr == 8'h8c && reg_wdata[0] && !core_reset_q;
   endsequence
   sequence scan_start;
      $fell(rx_power_n_q) && power_status_q && $past(power_status_q);
   endsequence
   int_gap_a: assert property (clear_wr |-> ##2 int_n_q)
      else $error("interrupt line not released after clear");
   low_entry_a: assert property (zp_wr |-> ##[1:2] core_reset_q)
      else $error("zero-power request did not stop the core");
   zero_pins_a: assert property ($rose(power_status_q) |->
      rx_power_n_q && core_reset_q)
      else $error("zero-power entered with receiver or core on");
   idle_wait_a: assert property ($rose(power_status_q) |->
      quiet_cnt >= IDLE_LEN - 2)
      else $error("zero-power entered while receive pin active");
   scan_len_a: assert property ($rose(rx_power_n_q) &&
      power_status_q && $past(power_status_q) |->
      low_cnt >= PULSE_LEN - 1 && low_cnt <= PULSE_LEN + 1)
      else $error("scan pulse length wrong");
   scan_end_a: assert property (scan_start |->
      ##[1:LEN_MAX] (rx_power_n_q || !power_status_q))
      else $error("scan did not end");
   scan_gap_a: assert property ($rose(rx_power_n_q) &&
      power_status_q |-> ##[1:GAP_MAX] (!rx_power_n_q || !power_status_q))
      else $error("no scan within the interval");
   wake_int_a: assert property ($fell(core_reset_q) |->
      ##[0:4] !int_n_q)
      else $error("no interrupt after initialisation");
   mask_rd_a: assert property ($past(reg_addr) == 8'h88 |->
      reg_rdata_q[7:4] == 4'h0)
      else $error("reserved mask bits read nonzero");
endmodule // power_wake_properties
bind power_wake_interrupt_logic power_wake_properties #(
   .SCAN_PERIOD(SCAN_PERIOD), .PULSE_LEN(PULSE_LEN), .IDLE_LEN(IDLE_LEN)
) i_power_wake_properties (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
   .rx_in(rx_in), .int_n_q(int_n_q), .power_status_q(power_status_q),
   .rx_power_n_q(rx_power_n_q), .core_reset_q(core_reset_q));

/* File: sim/host_port_model.sv */
// Purpose: Host controller on the register port and wake pins.
// Assumes: Drives at the falling edge, device samples at the rising.
// Notes: Pins idle high; pin index equals the port mode.
`timescale 1ns/1ns
module host_port_model (
   // Clock and device answers
   input wire clk,
   input wire int_n_q,
   input wire [7:0] reg_rdata_q,
   // Register port
   output logic reg_wr,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   // Wake pins: data line, select, write strobe
   output logic [2:0] pins
);
   // Idle port at time zero
   initial begin
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      pins = 3'b111;
   end
   // One write, strobe held over exactly one rising edge
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = ~d; // Stale data must not be relied on
   endtask
   // Read data follows the address one edge later
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      @(negedge clk);
      d = reg_rdata_q;
   endtask
   // Two falls, each held past the two-flop synchroniser
   task falls(input int m);
      repeat (2) begin
         @(negedge clk);
         pins[m] = 1'b0;
         repeat (4) @(negedge clk);
         pins[m] = 1'b1;
         repeat (4) @(negedge clk);
      end
   endtask
   // Wait up to 60 cycles for the power-up event, then clear it
   task service(output bit ok);
      ok = 1'b0;
      for (int i = 0; i < 60 && !ok; i++) begin
         @(negedge clk);
         ok = (int_n_q === 1'b0);
      end
      if (ok) wr(8'h86, 8'h04);
   endtask
endmodule // host_port_model

/* File: sim/test_power_wake_interrupt_logic.sv */
// Purpose: Self-checking bench of power states and host interrupt.
// Assumes: Short scan, pulse and idle counts set at the instance.
// Notes: Inputs change at the falling edge only.
`timescale 1ns/1ns
module test_power_wake_interrupt_logic;
   logic clk, arst_n, rx_in, wake_frame, msg_sent, tx_ok;
   logic msg_received, err_event;
   logic [1:0] port_mode;
   logic [7:0] tx_err_code, rx_type_in, node_count_in, node_delay_in;
   wire reg_wr, int_n_q, power_status_q, rx_power_n_q, core_reset_q;
   wire [7:0] reg_addr, reg_wdata, reg_rdata_q;
   wire [2:0] pins;
   int err_count, num_checks;
   host_port_model i_host_port_model (.clk(clk), .int_n_q(int_n_q),
      .reg_rdata_q(reg_rdata_q), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .pins(pins));
   power_wake_interrupt_logic #(.SCAN_PERIOD(200), .PULSE_LEN(20),
      .IDLE_LEN(16), .INIT_LEN(16)) i_power_wake_interrupt_logic (
      .clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
      .port_mode(port_mode), .sda_in(pins[0]), .cs_n_in(pins[1]),
      .wr_n_in(pins[2]), .rx_in(rx_in), .wake_frame(wake_frame),
      .msg_sent(msg_sent), .tx_ok(tx_ok), .tx_err_code(tx_err_code),
      .msg_received(msg_received), .rx_type_in(rx_type_in),
      .err_event(err_event), .node_count_in(node_count_in),
      .node_delay_in(node_delay_in), .int_n_q(int_n_q),
      .power_status_q(power_status_q), .rx_power_n_q(rx_power_n_q),
      .core_reset_q(core_reset_q));
   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   function logic [7:0] exp_int(input logic [7:0] m, input int e);
      return {7'h00, ~m[e]};
   endfunction
   task complete_run;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Bounded wait: 0 interrupt, 1 power status, 2 receiver, 3 core reset
   task wait_for(input int sel, input logic v, input int lim);
      logic s;
      int i;
      for (i = 0; i < lim; i++) begin
         @(negedge clk);
         s = sel == 0 ? int_n_q : sel == 1 ? power_status_q :
            sel == 2 ? rx_power_n_q : core_reset_q;
         if (s === v) break;
      end
      if (i == lim) begin
         err_count++;
         $display("MISMATCH at %0t seen %h expected %h", $time, s, v);
         complete_run();
      end
   endtask
   // Event pulse, or a node count or delay step for a config change
   task fire(input int e);
      @(negedge clk);
      case (e)
         0: msg_received = 1'b1;
         1: msg_sent = 1'b1;
         2: err_event = 1'b1;
         3: node_count_in = node_count_in + 8'h01;
         default: node_delay_in = node_delay_in + 8'h01;
      endcase
      @(negedge clk);
      msg_received = 1'b0;
      msg_sent = 1'b0;
      err_event = 1'b0;
      repeat (4) @(negedge clk);
   endtask
   task enter_zero(input bit busy);
      // Busy means the receive pin is already moving when the request lands
      repeat (busy ? 4 : 0) begin
         @(negedge clk);
         rx_in = ~rx_in;
      end
      i_host_port_model.wr(8'h8c, 8'h01);
      @(negedge clk);
      repeat (busy ? 30 : 0) begin
         @(negedge clk);
         rx_in = ~rx_in;
      end
      check({7'h00, core_reset_q}, 8'h01);
      check({7'h00, power_status_q}, {7'h00, !busy});
      wait_for(1, 1'b1, 60);
      check({7'h00, rx_power_n_q}, 8'h01);
   endtask
   task woke;
      logic [7:0] d;
      bit ok;
      wait_for(3, 1'b0, 60);
      wait_for(0, 1'b0, 6);
      i_host_port_model.rd(8'h85, d);
      check(d & 8'h04, 8'h04);
      i_host_port_model.service(ok);
      check({7'h00, ok}, 8'h01);
   endtask
   // Main sequence
   initial begin
      logic [7:0] m, d, a;
      int e;
      bit ok;
      {arst_n, rx_in, wake_frame, msg_sent, tx_ok} = 5'h00;
      {msg_received, err_event, port_mode} = 4'h0;
      {tx_err_code, rx_type_in, node_count_in, node_delay_in} = 32'h0;
      err_count = 0;
      num_checks = 0;
      d = $urandom(32'hb1bf);
      repeat (4) @(negedge clk);
      arst_n = 1'b1;
      wait_for(0, 1'b0, 30);
      i_host_port_model.rd(8'h88, d);
      check(d, 8'h00);
      i_host_port_model.service(ok);
      repeat (3) @(negedge clk);
      check({7'h00, int_n_q}, 8'h01);
      // Every event with its enable set, then with it clear, each then cleared
      for (int k = 0; k < 8; k++) begin
         e = k % 4;
         m = $urandom;
         m[e] = (k < 4);
         tx_ok = (k >= 4);
         tx_err_code = $urandom;
         rx_type_in = $urandom;
         i_host_port_model.wr(8'h88, m);
         i_host_port_model.rd(8'h88, d);
         check(d, m & 8'h0f);
         fire(k == 7 ? 4 : e);
         check({7'h00, int_n_q}, exp_int(m, e));
         i_host_port_model.rd(8'h85, d);
         check((d >> e) & 8'h01, 8'h01);
         if (e == 1) check((d >> 4) & 8'h01, {7'h00, tx_ok});
         i_host_port_model.rd(e == 1 ? 8'h87 : 8'h89, d);
         if (e == 0) check(d, rx_type_in);
         if (e == 1 && !tx_ok) check(d, tx_err_code);
         i_host_port_model.wr(8'h86, 8'h1f);
         repeat (3) @(negedge clk);
         check({7'h00, int_n_q}, 8'h01);
      end
      // Two pending events, the first cleared
      i_host_port_model.wr(8'h88, 8'h0f);
      fire(3);
      fire(1);
      i_host_port_model.wr(8'h86, 8'h08);
      @(negedge clk);
      check({7'h00, int_n_q}, 8'h01);
      @(negedge clk);
      check({7'h00, int_n_q}, 8'h00);
      i_host_port_model.wr(8'h86, 8'h02);
      // Zero-power while busy; empty scan, then receive wake
      a = $urandom;
      i_host_port_model.wr(8'h8d, a);
      enter_zero(1'b1);
      wait_for(2, 1'b0, 250);
      wait_for(2, 1'b1, 40);
      check({7'h00, power_status_q}, 8'h01);
      wait_for(2, 1'b0, 250);
      rx_in = 1'b1; // Receive pin driven high while receiver on
      woke();
      i_host_port_model.rd(8'h8d, d);
      check(d, a);
      i_host_port_model.rd(8'h88, d);
      check(d, 8'h00);
      // Host pin wakes in every port mode
      for (int p = 0; p < 3; p++) begin
         port_mode = p[1:0];
         enter_zero(1'b0);
         i_host_port_model.falls(p);
         woke();
      end
      // Network wake frame while still in low-power
      i_host_port_model.wr(8'h8c, 8'h01);
      wake_frame = 1'b1;
      @(negedge clk);
      wake_frame = 1'b0;
      check({7'h00, power_status_q}, 8'h00);
      woke();
      // Reset in mid-run
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      wait_for(0, 1'b0, 30);
      complete_run();
   end
endmodule // test_power_wake_interrupt_logic
